// >>> rtl/sra_top.sv
/*
  Stream resource allocator: executes allocate, release-identifier and
  release-resources directive operations, one command per cycle.
  Assumes commands arrive from logic on sys_clk, one-cycle valid strobe,
  and that grants apply to the requesting host across all its controllers.
*/
// Behaviour
// - Opcode 03h requests an exclusive stream grant for the named namespace.
// - Allocation ignores the directive-specific field in command word 11.
// - Granted count goes in completion word 0 bits 15:0; 31:16 zero.
// - Granted count never exceeds the requested count; fewer is allowed.
// - Parameter structure allocated field shows the same granted count.
// - No exclusive grant possible: complete with allocation-failure status.
// - Alternatively, with shared pool left, return granted count 0000h.
// - Allocation on a namespace already holding a grant: invalid-field status.
// - Requested count sits in command word 12 bits 15:0; upper reserved.
// - A grant is usable by all controllers of the same host.
// - Opcode 01h retires the stream identifier from command word 11.
// - Retiring an unknown identifier still completes successfully.
// - Retired resources stay with a granted namespace, else return to pool.
// - Identifier retire naming all-namespaces value is invalid-field.
// - Opcode 02h frees all resources granted to the namespace.
// - After release-resources the namespace's granted count reads 0h.
// - Release-resources with no grant completes successfully.
// - Parameter structure carries the granted count at bytes 23:22.
// - Zero grant means open streams are bounded by the shared pool size.
module sra_top #(
  parameter int NS_COUNT  = 4,
  parameter int NS_BITS   = 2,
  parameter int POOL_SIZE = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             cmd_valid,
  input  wire sra_pkg::sra_cmd_t cmd,
  input  wire logic             fail_on_empty,
  input  wire logic             stream_open_req,
  input  wire logic [NS_BITS-1:0] stream_open_ns,
  input  wire logic [NS_BITS-1:0] param_ns,
  output logic                  cpl_valid,
  output sra_pkg::sra_cpl_t     cpl,
  output logic [31:0]           param_word,
  output logic                  stream_open_ok,
  output logic [15:0]           pool_free
);

  typedef struct packed {
    logic [NS_COUNT-1:0][15:0] grant;
    logic [NS_COUNT-1:0][15:0] open_cnt;
    logic [15:0]               pool;
    logic                      cpl_valid;
    sra_pkg::sra_cpl_t         cpl;
    logic [31:0]               param_word;
    logic                      open_ok;
  } sra_state_t;

  sra_state_t state_reg;
  sra_state_t state_next;

  // Namespace index from the selector; selectors are 1-based
  function automatic logic [NS_BITS-1:0] ns_index(input logic [31:0] sel);
    logic [31:0] idx;
    idx = sel - 32'h00000001;
    return idx[NS_BITS-1:0];
  endfunction

  function automatic logic ns_valid(input logic [31:0] sel);
    return (sel != 32'h00000000) && (sel <= 32'(NS_COUNT));
  endfunction

  // Grant is the smaller of request and free pool, never above the request
  function automatic logic [15:0] clamp_grant(input logic [15:0] want, input logic [15:0] avail);
    return (want < avail) ? want : avail;
  endfunction

  // Per-namespace grant-held flags, one comparator each
  logic [NS_COUNT-1:0] held;

  genvar g;
  generate
    for (g = 0; g < NS_COUNT; g++)
    begin : g_held
      assign held[g] = (state_reg.grant[g] != sra_pkg::CNT_ZERO);
    end
  endgenerate

  // Single next-state process: command decode, pool, grants and stream usage
  always_comb
  begin
    logic [NS_BITS-1:0] ni;
    logic [15:0]        req;
    logic [15:0]        give;
    logic [15:0]        sid;
    state_next = state_reg;
    ni   = ns_index(cmd.ns_sel);
    req  = cmd.cdw12[sra_pkg::CNT_MSB:sra_pkg::CNT_LSB];
    sid  = cmd.cdw11[sra_pkg::ID_MSB:sra_pkg::ID_LSB];
    give = sra_pkg::CNT_ZERO;
    state_next.cpl_valid = 1'b0;
    state_next.open_ok   = 1'b0;

    // Stream opens draw on the grant, or on the shared pool without one
    if (stream_open_req)
    begin
      if (held[stream_open_ns])
      begin
        if (state_reg.open_cnt[stream_open_ns] < state_reg.grant[stream_open_ns])
        begin
          state_next.open_cnt[stream_open_ns] = state_reg.open_cnt[stream_open_ns] + 16'h0001;
          state_next.open_ok = 1'b1;
        end
      end
      else if (state_reg.pool != sra_pkg::CNT_ZERO)
      begin
        state_next.open_cnt[stream_open_ns] = state_reg.open_cnt[stream_open_ns] + 16'h0001;
        state_next.pool    = state_reg.pool - 16'h0001;
        state_next.open_ok = 1'b1;
      end
    end

    // Clamp against the pool left after a same-cycle open, so it cannot wrap
    give = clamp_grant(req, state_next.pool);

    if (cmd_valid)
    begin
      state_next.cpl_valid  = 1'b1;
      state_next.cpl.dw0    = 32'h00000000;
      state_next.cpl.status = sra_pkg::ST_SUCCESS;
      case (cmd.op)
        sra_pkg::OP_ALLOC:
        begin
          if (!ns_valid(cmd.ns_sel))
            state_next.cpl.status = sra_pkg::ST_INVALID_FLD;
          else if (held[ni])
            state_next.cpl.status = sra_pkg::ST_INVALID_FLD;
          else if (give == sra_pkg::CNT_ZERO)
          begin
            // No grant possible: fail, or with pool left and fail_on_empty low report zero and share the pool
            if (fail_on_empty || state_next.pool == sra_pkg::CNT_ZERO)
              state_next.cpl.status = sra_pkg::ST_ALLOC_FAIL;
            else
              state_next.cpl.dw0 = 32'h00000000;
          end
          else
          begin
            // One grant table per host, so all its controllers see it
            state_next.grant[ni]   = give;
            state_next.pool        = state_next.pool - give;
            state_next.cpl.dw0     = {16'h0000, give};
          end
        end
        sra_pkg::OP_RELEASE_ID:
        begin
          if (cmd.ns_sel == sra_pkg::NS_ALL || !ns_valid(cmd.ns_sel))
            state_next.cpl.status = sra_pkg::ST_INVALID_FLD;
          else if (sid != 16'h0000 && state_next.open_cnt[ni] != sra_pkg::CNT_ZERO)
          begin
            // Identifier tracking is by count only; unknown ids just succeed
            state_next.open_cnt[ni] = state_next.open_cnt[ni] - 16'h0001;
            if (state_reg.grant[ni] == sra_pkg::CNT_ZERO)
              state_next.pool = state_next.pool + 16'h0001;
          end
        end
        sra_pkg::OP_RELEASE_RES:
        begin
          if (!ns_valid(cmd.ns_sel))
            state_next.cpl.status = sra_pkg::ST_INVALID_FLD;
          else if (state_reg.grant[ni] != sra_pkg::CNT_ZERO)
          begin
            state_next.pool         = state_next.pool + state_reg.grant[ni];
            state_next.grant[ni]    = sra_pkg::CNT_ZERO;
            state_next.open_cnt[ni] = sra_pkg::CNT_ZERO;
          end
        end
        default:
          state_next.cpl.status = sra_pkg::ST_INVALID_OP;
      endcase
    end

    // Parameter word: bytes 23:22 of the structure sit in bits 31:16
    state_next.param_word = {state_next.grant[param_ns], 16'h0000};
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg      <= '0;
      state_reg.pool <= 16'(POOL_SIZE);
    end
    else
      state_reg <= state_next;
  end

  assign cpl_valid      = state_reg.cpl_valid;
  assign cpl            = state_reg.cpl;
  assign param_word     = state_reg.param_word;
  assign stream_open_ok = state_reg.open_ok;
  assign pool_free      = state_reg.pool;

endmodule

// >>> rtl/sra_pkg.sv
/*
  Package for the stream resource allocator: operation codes, field
  positions, status codes and the command/completion carriers.
  Assumes a single 100 MHz clock domain and a command source on that clock.
*/
package sra_pkg;

  // Directive operation codes
  localparam logic [7:0]  OP_ALLOC       = 8'h03;
  localparam logic [7:0]  OP_RELEASE_ID  = 8'h01;
  localparam logic [7:0]  OP_RELEASE_RES = 8'h02;

  // Command word field positions
  localparam int          CNT_LSB        = 0;
  localparam int          CNT_MSB        = 15;
  localparam int          ID_LSB         = 16;
  localparam int          ID_MSB         = 31;
  localparam logic [31:0] NS_ALL         = 32'hffffffff;

  // Parameter structure byte position of the granted count
  localparam int          PARAM_GRANT_LO = 22;
  localparam int          PARAM_GRANT_HI = 23;

  // Completion status codes
  localparam logic [7:0]  ST_SUCCESS     = 8'h00;
  localparam logic [7:0]  ST_INVALID_FLD = 8'h02;
  localparam logic [7:0]  ST_ALLOC_FAIL  = 8'h7f;
  localparam logic [7:0]  ST_INVALID_OP  = 8'h01;

  localparam logic [15:0] CNT_ZERO       = 16'h0000;

  // Command as presented by the queue front end
  typedef struct packed {
    logic [7:0]  op;
    logic [31:0] ns_sel;
    logic [31:0] cdw11;
    logic [31:0] cdw12;
  } sra_cmd_t;

  // Completion entry fields
  typedef struct packed {
    logic [31:0] dw0;
    logic [7:0]  status;
  } sra_cpl_t;

endpackage

// >>> testbench/sra_top_asserts.sv
/* Checker for sra_top: completion timing, grant and pool relations.
   Assumes one clock and a synchronous active-low reset. */
module sra_checker #(
  parameter int NS_COUNT = 4,
  parameter int NS_BITS  = 2
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              cmd_valid,
  input wire sra_pkg::sra_cmd_t cmd,
  input wire logic              stream_open_req,
  input wire logic [NS_BITS-1:0] param_ns,
  input wire logic              cpl_valid,
  input wire sra_pkg::sra_cpl_t cpl,
  input wire logic [31:0]       param_word,
  input wire logic [15:0]       pool_free
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_CPL_LAT: assert property (cmd_valid |=> cpl_valid) else $error("no completion");
  AST_CPL_NONE: assert property (!cmd_valid |=> !cpl_valid) else $error("stray completion");
  AST_DW0_HI: assert property (cpl_valid |-> cpl.dw0[31:16] == 16'h0) else $error("dw0 upper set");
  AST_GRANT_LE: assert property (cmd_valid && cmd.op == sra_pkg::OP_ALLOC |=>
    cpl.status != sra_pkg::ST_SUCCESS || cpl.dw0[15:0] <= $past(cmd.cdw12[15:0])) else $error("over grant");
  AST_POOL_DEC: assert property (cmd_valid && cmd.op == sra_pkg::OP_ALLOC && !stream_open_req |=>
    cpl.status != sra_pkg::ST_SUCCESS || pool_free == $past(pool_free) - cpl.dw0[15:0]) else $error("pool");
  AST_ALL_NS: assert property (cmd_valid && cmd.op == sra_pkg::OP_RELEASE_ID && cmd.ns_sel == sra_pkg::NS_ALL
    |=> cpl.status == sra_pkg::ST_INVALID_FLD) else $error("all-ns accepted");
  AST_REL_OK: assert property (cmd_valid && cmd.op == sra_pkg::OP_RELEASE_RES && cmd.ns_sel != 32'h0 &&
    cmd.ns_sel <= NS_COUNT |=> cpl.status == sra_pkg::ST_SUCCESS) else $error("release failed");
  AST_REL_ZERO: assert property (cmd_valid && cmd.op == sra_pkg::OP_RELEASE_RES &&
    cmd.ns_sel == 32'(param_ns) + 32'h1 |=> param_word[31:16] == 16'h0) else $error("grant kept");
endmodule

bind sra_top sra_checker #(.NS_COUNT(NS_COUNT), .NS_BITS(NS_BITS)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd(cmd), .stream_open_req(stream_open_req), .param_ns(param_ns),
  .cpl_valid(cpl_valid), .cpl(cpl), .param_word(param_word), .pool_free(pool_free));

// >>> testbench/sra_host_model.sv
/* Host software model: presents one queued command per strobe.
   Assumes the bench changes go and go_cmd just after a falling edge. */
module sra_host_model (
  input  wire logic              go,
  input  wire sra_pkg::sra_cmd_t go_cmd,
  output logic                   cmd_valid,
  output sra_pkg::sra_cmd_t      cmd
);
  // Idle fields scrambled so nothing leans on stale values
  assign cmd_valid = go;
  assign cmd       = go ? go_cmd : ~go_cmd;
endmodule

// >>> testbench/sra_top_bench.sv
/* Self-checking bench for sra_top: allocate, retire, release.
   Assumes default parameters: four namespaces, pool of 16. */
module sra_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              go = 1'b0;
  sra_pkg::sra_cmd_t go_cmd = '0;
  logic              fail_on_empty = 1'b1;
  logic              open_req = 1'b0;
  logic              cmd_valid, cpl_valid, open_ok;
  sra_pkg::sra_cmd_t cmd;
  sra_pkg::sra_cpl_t cpl;
  logic [31:0]       param_word;
  logic [15:0]       pool_free;
  int                err_count = 0;
  int                cmp_count = 0;

  always #5 sys_clk = ~sys_clk;

  sra_host_model i_host (.go(go), .go_cmd(go_cmd), .cmd_valid(cmd_valid), .cmd(cmd));
  sra_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .fail_on_empty(fail_on_empty), .stream_open_req(open_req), .stream_open_ns(2'h2), .param_ns(2'h0),
    .cpl_valid(cpl_valid), .cpl(cpl), .param_word(param_word), .stream_open_ok(open_ok), .pool_free(pool_free));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Completion is registered, so look one cycle after the strobe
  task automatic issue(input logic [7:0] op, input logic [31:0] ns, c11, c12, input logic [7:0] st);
    @(negedge sys_clk);
    go = 1'b1;
    go_cmd = {op, ns, c11, c12};
    @(negedge sys_clk);
    go = 1'b0;
    chk(32'(cpl_valid), 32'h1);
    chk(32'(cpl.status), 32'(st));
  endtask

  task automatic t_alloc;
    issue(sra_pkg::OP_ALLOC, 32'h1, 32'hffffffff, 32'h5, sra_pkg::ST_SUCCESS);
    chk(cpl.dw0, 32'h5);
    chk(param_word, 32'h50000);
    issue(sra_pkg::OP_ALLOC, 32'h1, 32'h0, 32'h3, sra_pkg::ST_INVALID_FLD);
    issue(sra_pkg::OP_ALLOC, 32'h2, 32'h0, 32'h14, sra_pkg::ST_SUCCESS);
    chk(cpl.dw0, 32'hb);
    issue(sra_pkg::OP_ALLOC, 32'h3, 32'h0, 32'h3, sra_pkg::ST_ALLOC_FAIL);
    $display("test alloc done");
  endtask

  task automatic t_release;
    issue(sra_pkg::OP_RELEASE_ID, 32'h1, 32'h70000, 32'h0, sra_pkg::ST_SUCCESS);
    issue(sra_pkg::OP_RELEASE_ID, sra_pkg::NS_ALL, 32'h10000, 32'h0, sra_pkg::ST_INVALID_FLD);
    issue(sra_pkg::OP_RELEASE_RES, 32'h1, 32'h0, 32'h0, sra_pkg::ST_SUCCESS);
    chk(param_word, 32'h0);
    chk(32'(pool_free), 32'h5);
    issue(sra_pkg::OP_RELEASE_RES, 32'h1, 32'h0, 32'h0, sra_pkg::ST_SUCCESS);
    issue(sra_pkg::OP_RELEASE_RES, 32'h2, 32'h0, 32'h0, sra_pkg::ST_SUCCESS);
    chk(32'(pool_free), 32'h10);
    $display("test release done");
  endtask

  // Zero grant: the open draws on the shared pool, retire gives it back
  task automatic t_shared;
    fail_on_empty = 1'b0;
    issue(sra_pkg::OP_ALLOC, 32'h3, 32'h0, 32'h0, sra_pkg::ST_SUCCESS);
    chk(cpl.dw0, 32'h0);
    @(negedge sys_clk);
    open_req = 1'b1;
    @(negedge sys_clk);
    open_req = 1'b0;
    chk(32'(open_ok), 32'h1);
    chk(32'(pool_free), 32'hf);
    issue(sra_pkg::OP_RELEASE_ID, 32'h3, 32'h10000, 32'h0, sra_pkg::ST_SUCCESS);
    chk(32'(pool_free), 32'h10);
    $display("test shared done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(negedge sys_clk);
    chk(32'(pool_free), 32'h10);
    rst_n = 1'b1;
    t_alloc;
    t_release;
    t_shared;
    tally_and_finish;
  end

  // Run needs about 36 cycles; over ten times that is a hang
  initial
  begin
    #5000;
    err_count++;
    tally_and_finish;
  end
endmodule
